// ### pkg/crps_defs.svh
`ifndef CRPS_DEFS_SVH
`define CRPS_DEFS_SVH
// ==========================================================
// timing constants
`define CRPS_CLK_NS            32'd40
`define CRPS_FAST_PARK_NS      32'd32000
// fast park length in cycles, rounded down (shortest time)
`define CRPS_FAST_PARK_CYC     ((`CRPS_FAST_PARK_NS) / (`CRPS_CLK_NS))
`define CRPS_CNT_W             10
// general purpose pin count
`define CRPS_GPIO_W            20
// reset values of driven levels
`define CRPS_SEL_RESET         1'b0
`define CRPS_OE_OFF            1'b1
`endif

// ### pkg/crps_pkg.sv
package crps_pkg;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    crps_st_pll    = 3'h0,
    crps_st_load   = 3'h1,
    crps_st_run    = 3'h2,
    crps_st_fpark  = 3'h3,
    crps_st_parked = 3'h4
  } crps_state_e;

  // flash port request/answer
  typedef struct packed {
    logic start;
    logic done;
  } crps_load_s;
endpackage

// ### core/crps_sync.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// three-stage pin synchroniser; output changes when stages two and three agree
module crps_sync (
  input  wire logic clk_sys_in,
  input  wire logic reset_in,
  input  wire logic pin_in,
  output var  logic level_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } crps_sync_s;
  crps_sync_s st_reg;   // stage state
  crps_sync_s st_next;  // next stage state

  // shift stages; update level on agreement
  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end

  // register with reset to inactive-high level
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_reg <= 4'hF;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level_out = st_reg.lvl;
endmodule
`default_nettype wire

// ### core/crps_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "crps_defs.svh"
module crps_sequencer (
  input  wire logic                     clk_sys_in,          // 25 MHz system clock
  input  wire logic                     reset_in,            // synchronous reset, high
  input  wire logic                     pll_locked_in,       // pll lock indication
  input  wire logic                     load_done_in,        // flash load finished, pulse
  input  wire logic                     fast_park_request_low_in, // async pin, active low
  input  wire logic                     projector_enable_in, // async pin
  input  wire logic [`CRPS_GPIO_W-1:0]  gpio_data_in,        // gpio levels from core
  input  wire logic [`CRPS_GPIO_W-1:0]  gpio_oe_low_in,      // gpio drive request, low drives
  input  wire logic                     flash_serial_clock_in,    // flash port levels from core
  input  wire logic                     flash_serial_data_out_in,
  input  wire logic                     flash_select_zero_in,
  input  wire logic                     flash_select_one_in,
  input  wire logic                     light_select_zero_in,
  input  wire logic                     light_select_one_in,
  output logic                          load_start_out,      // flash load request pulse
  output logic                          host_status_out,     // status flag level
  output logic                          host_status_oe_low_out, // status flag drive, low drives
  output logic                          flash_serial_clock_out,
  output logic                          flash_serial_data_out_out,
  output logic                          flash_select_zero_out,
  output logic                          flash_select_one_out,
  output logic                          flash_oe_low_out,    // flash pins drive, low drives
  output logic [`CRPS_GPIO_W-1:0]       gpio_out,
  output logic [`CRPS_GPIO_W-1:0]       gpio_oe_low_out,
  output logic                          light_select_zero_out,
  output logic                          light_select_one_out,
  output logic                          mirror_drive_enable_low_out,
  output logic                          projector_enable_out, // synchronised enable
  output logic                          parked_out            // fast park complete
);
  // ==========================================================
  // synchronised inputs
  logic park_low_sync;  // synchronised park request
  logic enable_sync;    // synchronised projector enable

  crps_sync u_sync_park (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (fast_park_request_low_in),
    .level_out  (park_low_sync)
  );

  crps_sync u_sync_en (
    .clk_sys_in (clk_sys_in),
    .reset_in   (reset_in),
    .pin_in     (projector_enable_in),
    .level_out  (enable_sync)
  );

  // ==========================================================
  // state record
  typedef struct packed {
    crps_pkg::crps_state_e     state;
    logic [`CRPS_CNT_W-1:0]    cnt;
    logic                      load_start;
    logic                      status;
    logic                      status_oe_low;
    logic                      fl_clk;
    logic                      fl_dout;
    logic                      fl_cs0;
    logic                      fl_cs1;
    logic                      fl_oe_low;
    logic [`CRPS_GPIO_W-1:0]   gpio;
    logic [`CRPS_GPIO_W-1:0]   gpio_oe_low;
    logic                      sel0;
    logic                      sel1;
    logic                      mden_low;
    logic                      en;
    logic                      parked;
  } crps_state_s;
  crps_state_s st_reg;   // registered state
  crps_state_s st_next;  // next state

  // ==========================================================
  // sequencing logic
  always_comb begin
    st_next            = st_reg;
    st_next.load_start = 1'b0;
    st_next.en         = enable_sync;
    // flash pins active after release, gpio drive follows the core request, parked state keeps mirror idle
    st_next.fl_clk      = flash_serial_clock_in;
    st_next.fl_dout     = flash_serial_data_out_in;
    st_next.fl_cs0      = flash_select_zero_in;
    st_next.fl_cs1      = flash_select_one_in;
    st_next.fl_oe_low   = 1'b0;
    st_next.gpio        = gpio_data_in;
    st_next.gpio_oe_low = gpio_oe_low_in;
    st_next.sel0        = light_select_zero_in;
    st_next.sel1        = light_select_one_in;
    case (st_reg.state)
      crps_pkg::crps_st_pll: begin
        // flag driven high while initialising
        st_next.status        = 1'b1;
        st_next.status_oe_low = 1'b0;
        st_next.mden_low      = 1'b0;
        if (pll_locked_in) begin
          st_next.state      = crps_pkg::crps_st_load;
          st_next.load_start = 1'b1;
        end
      end
      crps_pkg::crps_st_load: begin
        if (load_done_in) begin
          st_next.state  = crps_pkg::crps_st_run;
          st_next.status = 1'b0;
        end
      end
      crps_pkg::crps_st_run: begin
        // mirror drive follows projector enable
        st_next.mden_low = enable_sync;
        if (!park_low_sync) begin
          st_next.state = crps_pkg::crps_st_fpark;
          st_next.cnt   = '0;
        end
      end
      crps_pkg::crps_st_fpark: begin
        // mirrors idled, count park window
        st_next.mden_low = 1'b0;
        st_next.sel0     = 1'b0;
        st_next.sel1     = 1'b0;
        if (st_reg.cnt == `CRPS_CNT_W'(`CRPS_FAST_PARK_CYC - 1)) begin
          st_next.state  = crps_pkg::crps_st_parked;
          st_next.parked = 1'b1;
        end else begin
          st_next.cnt = st_reg.cnt + `CRPS_CNT_W'(1);
        end
      end
      crps_pkg::crps_st_parked: begin
        // stay parked until reset
        st_next.mden_low = 1'b0;
        st_next.sel0     = 1'b0;
        st_next.sel1     = 1'b0;
      end
      default: begin
        st_next.state = crps_pkg::crps_st_pll;
      end
    endcase
  end

  // ==========================================================
  // state register; reset forces safe pin states
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      st_reg               <= '0;
      st_reg.state         <= crps_pkg::crps_st_pll;
      st_reg.status_oe_low <= `CRPS_OE_OFF;
      st_reg.fl_oe_low     <= `CRPS_OE_OFF;
      st_reg.gpio_oe_low   <= {`CRPS_GPIO_W{`CRPS_OE_OFF}};
      st_reg.sel0          <= `CRPS_SEL_RESET;
      st_reg.sel1          <= `CRPS_SEL_RESET;
      st_reg.mden_low      <= `CRPS_SEL_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign load_start_out              = st_reg.load_start;
  assign host_status_out             = st_reg.status;
  assign host_status_oe_low_out      = st_reg.status_oe_low;
  assign flash_serial_clock_out      = st_reg.fl_clk;
  assign flash_serial_data_out_out   = st_reg.fl_dout;
  assign flash_select_zero_out       = st_reg.fl_cs0;
  assign flash_select_one_out        = st_reg.fl_cs1;
  assign flash_oe_low_out            = st_reg.fl_oe_low;
  assign gpio_out                    = st_reg.gpio;
  assign gpio_oe_low_out             = st_reg.gpio_oe_low;
  assign light_select_zero_out       = st_reg.sel0;
  assign light_select_one_out        = st_reg.sel1;
  assign mirror_drive_enable_low_out = st_reg.mden_low;
  assign projector_enable_out        = st_reg.en;
  assign parked_out                  = st_reg.parked;

  // ==========================================================
  // assertions
  reset_pins_a: assert property (@(posedge clk_sys_in) $past(reset_in) |->
    flash_oe_low_out && (&gpio_oe_low_out)) else $error("pins not tri-stated in reset");
  reset_low_a: assert property (@(posedge clk_sys_in) $past(reset_in) |->
    !light_select_zero_out && !light_select_one_out && !mirror_drive_enable_low_out)
    else $error("drive outputs not low in reset");
  reset_quiet_a: assert property (@(posedge clk_sys_in) $past(reset_in) |->
    !load_start_out && !parked_out) else $error("active output in reset");
  flag_high_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $past(reset_in) ##0 !reset_in |=> host_status_out && !host_status_oe_low_out)
    else $error("status flag not driven high after release");
  load_order_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    load_start_out |-> $past(pll_locked_in)) else $error("load before pll lock");
  flag_done_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (st_reg.state == crps_pkg::crps_st_load) && load_done_in |=> !host_status_out)
    else $error("status flag not low after load");
  park_start_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (st_reg.state == crps_pkg::crps_st_run) && !park_low_sync |=> ##[1:2]
    !mirror_drive_enable_low_out) else $error("fast park did not idle mirrors");
  park_end_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(parked_out) |-> $past(st_reg.state) == crps_pkg::crps_st_fpark)
    else $error("parked without fast park");
  pins_active_a: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $past(reset_in) && !reset_in |=> !flash_oe_low_out) else $error("flash pins not active");
endmodule
`default_nettype wire

// ### testbench/crps_pmic_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// power manager model: drives reset and the park warning
module crps_pmic_model (
  input  wire logic clk_sys_in,
  input  wire logic release_cmd_in,        // bench asks to release reset
  input  wire logic fault_cmd_in,          // bench reports power loss
  output var  logic reset_out,             // high while system reset held
  output var  logic fast_park_request_low_out
);
  logic [9:0] hold_reg;                    // cycles left before reset allowed
  initial begin
    reset_out = 1'b1;
    fast_park_request_low_out = 1'b0;
    hold_reg = 10'h000;
  end
  // ==========================================================
  // park pin goes high during reset, low on fault only
  always @(posedge clk_sys_in) begin
    if (fault_cmd_in && fast_park_request_low_out) begin
      fast_park_request_low_out <= 1'b0;
      hold_reg <= 10'h320;
    end else if (hold_reg != 10'h000) begin
      hold_reg <= hold_reg - 10'h001;
    end else if (reset_out && !fault_cmd_in) begin
      fast_park_request_low_out <= 1'b1;
    end
    // release only once park pin high; reassert only after hold
    if (!release_cmd_in && hold_reg == 10'h000) begin
      reset_out <= 1'b1;
    end else if (release_cmd_in && fast_park_request_low_out) begin
      reset_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### testbench/crps_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module crps_sequencer_bench;
  // ==========================================================
  // signals
  logic        clk_sys_in, reset_in, park_low, rel_cmd, fault_cmd;
  logic        pll_locked, load_done, proj_en, ld_start, st, st_oe_low;
  logic        fclk, fdat, fs0, fs1, f_oe_low, ls0, ls1, mirror, proj_out, parked;
  logic [19:0] gpio_out, gpio_oe_low;
  logic [3:0]  fl_in;        // core flash levels: clock, data, select zero, select one
  logic [1:0]  ls_in;        // core light select levels
  logic        host_pin;     // status pin as the host sees it, pull-up when released
  assign host_pin = st_oe_low ? 1'b1 : st;
  int          fail_count, num_checks, n;
  crps_pmic_model i_pmic (.clk_sys_in(clk_sys_in), .release_cmd_in(rel_cmd), .fault_cmd_in(fault_cmd),
    .reset_out(reset_in), .fast_park_request_low_out(park_low));
  crps_sequencer i_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .pll_locked_in(pll_locked),
    .load_done_in(load_done), .fast_park_request_low_in(park_low), .projector_enable_in(proj_en),
    .gpio_data_in(20'hA5A5A), .gpio_oe_low_in(20'h0F0F0), .flash_serial_clock_in(fl_in[3]),
    .flash_serial_data_out_in(fl_in[2]), .flash_select_zero_in(fl_in[1]), .flash_select_one_in(fl_in[0]),
    .light_select_zero_in(ls_in[1]), .light_select_one_in(ls_in[0]), .load_start_out(ld_start),
    .host_status_out(st), .host_status_oe_low_out(st_oe_low), .flash_serial_clock_out(fclk),
    .flash_serial_data_out_out(fdat), .flash_select_zero_out(fs0), .flash_select_one_out(fs1),
    .flash_oe_low_out(f_oe_low), .gpio_out(gpio_out), .gpio_oe_low_out(gpio_oe_low),
    .light_select_zero_out(ls0), .light_select_one_out(ls1), .mirror_drive_enable_low_out(mirror),
    .projector_enable_out(proj_out), .parked_out(parked));
  // ==========================================================
  // clock and shared tasks
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys_in);
    #1;
  endtask
  // compare one value, count it, report a mismatch
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // wait for a signal level under a bound, counting cycles
  task automatic wait_lvl(input string what, input int which, input logic v, input int bound);
    n = 0;
    while ((which == 0 ? st : which == 1 ? ld_start : which == 2 ? mirror : which == 3 ? parked : reset_in) !== v) begin
      tick(1);
      n++;
      if (n > bound) begin
        chk(what, 20'h1, 20'h0);
        summarize();
      end
    end
  endtask
  // ==========================================================
  // scenario: pin states held in reset
  task automatic test_reset();
    tick(10);
    chk("flash oe", 20'h1, {19'h0, f_oe_low});
    chk("gpio oe", 20'hFFFFF, gpio_oe_low);
    chk("flash pins", 20'h0, {16'h0, fclk, fdat, fs0, fs1});
    chk("selects", 20'h0, {17'h0, ls0, ls1, mirror});
    chk("status oe", 20'h1, {19'h0, st_oe_low});
    chk("load start", 20'h0, {19'h0, ld_start});
    chk("status pin idle", 20'h1, {19'h0, host_pin});
    $display("test reset done");
  endtask
  // scenario: release, pll lock, flash load, done flag
  task automatic test_init();
    @(posedge clk_sys_in) rel_cmd <= 1'b1;
    wait_lvl("release", 4, 1'b0, 20);
    tick(2);
    chk("status high", 20'h2, {18'h0, st, st_oe_low});
    chk("flash driven", 20'hF, {15'h0, f_oe_low, fclk, fdat, fs0, fs1});
    chk("gpio data", 20'hA5A5A, gpio_out);
    chk("gpio oe run", 20'h0F0F0, gpio_oe_low);
    // flash levels from the core pass through one edge later
    @(posedge clk_sys_in) fl_in <= 4'h6;
    tick(2);
    chk("flash follow", 20'h6, {16'h0, fclk, fdat, fs0, fs1});
    tick(4);
    chk("no early load", 20'h0, {19'h0, ld_start});
    @(posedge clk_sys_in) pll_locked <= 1'b1;
    wait_lvl("load start", 1, 1'b1, 5);
    tick(1);
    chk("load pulse", 20'h0, {19'h0, ld_start});
    chk("still busy", 20'h1, {19'h0, st});
    @(posedge clk_sys_in) load_done <= 1'b1;
    @(posedge clk_sys_in) load_done <= 1'b0;
    wait_lvl("status low", 0, 1'b0, 3);
    chk("status driven", 20'h0, {19'h0, st_oe_low});
    $display("test init done");
  endtask
  // scenario: fast park, then reset releases the flag
  task automatic test_park();
    tick(6);
    chk("mirror run", 20'h1, {19'h0, mirror});
    chk("enable sync", 20'h1, {19'h0, proj_out});
    chk("selects run", 20'h3, {18'h0, ls0, ls1});
    // normal park: enable dropped only after the flag went low
    @(posedge clk_sys_in) proj_en <= 1'b0;
    wait_lvl("normal park", 2, 1'b0, 8);
    chk("enable low", 20'h0, {19'h0, proj_out});
    chk("supplies kept", 20'h3, {18'h0, park_low, !reset_in});
    @(posedge clk_sys_in) proj_en <= 1'b1;
    wait_lvl("enable back", 2, 1'b1, 8);
    @(posedge clk_sys_in) fault_cmd <= 1'b1;
    tick(1);
    wait_lvl("mirror park", 2, 1'b0, 6);
    chk("selects park", 20'h0, {18'h0, ls0, ls1});
    chk("not parked", 20'h0, {19'h0, parked});
    wait_lvl("parked", 3, 1'b1, 810);
    chk("park length", 20'h1, {19'h0, n >= 790 && n <= 803});
    @(posedge clk_sys_in) rel_cmd <= 1'b0;
    wait_lvl("reset again", 4, 1'b1, 20);
    tick(2);
    chk("status released", 20'h1, {19'h0, st_oe_low});
    chk("status pulled up", 20'h1, {19'h0, host_pin});
    chk("oe off", 20'h1, {19'h0, f_oe_low});
    $display("test park done");
  endtask
  // ==========================================================
  // main sequence
  initial begin
    fail_count = 0;
    num_checks = 0;
    rel_cmd = 1'b0;
    fault_cmd = 1'b0;
    pll_locked = 1'b0;
    load_done = 1'b0;
    proj_en = 1'b1;
    fl_in = 4'hF;
    ls_in = 2'h3;
    test_reset();
    test_init();
    test_park();
    summarize();
  end
endmodule
`default_nettype wire
